/* File: shared/pafifo_pkg.sv */
package pafifo_pkg;

    // default port width and address width (depth is 2**addr width)
    localparam int unsigned DATA_WIDTH_DEF   = 4;
    localparam int unsigned ADDR_WIDTH_DEF   = 4;

    // default distances of the almost flags from full and from empty
    localparam int unsigned AFULL_OFFSET_DEF  = 2;
    localparam int unsigned AEMPTY_OFFSET_DEF = 2;

    // mode strings of the static mode setting
    localparam string MODE_SYNC  = "TRUE";
    localparam string MODE_ASYNC = "FALSE";

    // capabilities off unless asked for
    localparam bit REWRITE_DEF = 1'b0;
    localparam bit RESEND_DEF  = 1'b0;

    // flag values after reset: buffer empty
    localparam logic RST_FULL         = 1'b0;
    localparam logic RST_EMPTY        = 1'b1;
    localparam logic RST_ALMOST_FULL  = 1'b0;
    localparam logic RST_ALMOST_EMPTY = 1'b1;

    // synchroniser length for pins
    localparam int unsigned SYNC_STAGES = 2;

endpackage

/* File: hw/pafifo_sync.sv */
`timescale 1ns/100ps
// two-flop synchroniser for a group of pins sampled together
module pafifo_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] stab_q;
    logic [WIDTH-1:0] stab_d;

    // first flop feeds only the second one
    always_comb begin
        meta_d = pin_in;
        stab_d = meta_q;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            stab_q <= '0;
        end else begin
            meta_q <= meta_d;
            stab_q <= stab_d;
        end
    end

    assign sync_out = stab_q;

endmodule

/* File: hw/pafifo_ram.sv */
`timescale 1ns/100ps
// storage array: one write port, one asynchronous read port
module pafifo_ram #(
    parameter int unsigned DATA_WIDTH = pafifo_pkg::DATA_WIDTH_DEF,
    parameter int unsigned ADDR_WIDTH = pafifo_pkg::ADDR_WIDTH_DEF
) (
    input  wire logic                  sys_clk,
    input  wire logic                  wr_strobe,
    input  wire logic [ADDR_WIDTH-1:0] wr_addr,
    input  wire logic [DATA_WIDTH-1:0] wr_word,
    input  wire logic [ADDR_WIDTH-1:0] rd_addr,
    output logic      [DATA_WIDTH-1:0] rd_word
);

    logic [DATA_WIDTH-1:0] mem_q [0:(1<<ADDR_WIDTH)-1];

    // no reset on the array: content is only valid behind the pointers
    always_ff @(posedge sys_clk) begin
        if (wr_strobe) begin
            mem_q[wr_addr] <= wr_word;
        end
    end

    assign rd_word = mem_q[rd_addr];

endmodule

/* File: hw/pafifo_top.sv */
`timescale 1ns/100ps
// Function
// - memory array plus pointer and flag control section
// - static mode string TRUE is single clock, FALSE is dual clock
// - async mode: write actions on write clock, read actions on read clock
// - async: write when enabled and not full; writes while full ignored
// - async: read when enabled and not empty; reads while empty ignored
// - async: full flag lives in write clock domain
// - async: empty flag lives in read clock domain
// - sync mode: reads and writes both on the one shared clock
// - sync mode: full set when filled, empty set when drained
// - write, read and output register enables are active high
// - output data register updates only when its enable is high
// - packet error restores write pointer to packet start, dropping packet
// - rewrite can be enabled without resend
// - resend request restores read pointer to packet start
// - resend only works when rewrite is enabled too
// - empty clears one read clock after write (sync), two (async)
// - almost full at set threshold; write pointer stops when full
// - async: full clears two write clocks after a read
// - one data width parameter shared by both ports
module pafifo_top #(
    parameter int unsigned DATA_WIDTH    = pafifo_pkg::DATA_WIDTH_DEF,
    parameter int unsigned ADDR_WIDTH    = pafifo_pkg::ADDR_WIDTH_DEF,
    parameter string       SYNC_FIFO     = pafifo_pkg::MODE_SYNC,
    parameter bit          REWRITE_EN    = pafifo_pkg::REWRITE_DEF,
    parameter bit          RESEND_EN     = pafifo_pkg::RESEND_DEF,
    parameter int unsigned AFULL_OFFSET  = pafifo_pkg::AFULL_OFFSET_DEF,
    parameter int unsigned AEMPTY_OFFSET = pafifo_pkg::AEMPTY_OFFSET_DEF
) (
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  write_clock,
    input  wire logic                  write_enable,
    input  wire logic [DATA_WIDTH-1:0] data_in,
    input  wire logic                  write_packet_error,
    input  wire logic                  read_clock,
    input  wire logic                  read_enable,
    input  wire logic                  read_resend_request,
    input  wire logic                  output_register_enable,
    output logic      [DATA_WIDTH-1:0] data_out,
    output logic                       full_flag,
    output logic                       empty_flag,
    output logic                       almost_full_flag,
    output logic                       almost_empty_flag
);

    localparam int unsigned PW = ADDR_WIDTH + 1;
    localparam int unsigned WG = DATA_WIDTH + 3;
    localparam logic [PW-1:0] DEPTH = PW'(1 << ADDR_WIDTH);
    localparam logic [PW-1:0] AFULL_LEVEL =
        PW'((1 << ADDR_WIDTH) - AFULL_OFFSET);
    localparam logic [PW-1:0] AEMPTY_LEVEL = PW'(AEMPTY_OFFSET);
    localparam logic [PW-1:0] PTR_ONE = PW'(1);

    localparam bit SYNC_MODE = (SYNC_FIFO == pafifo_pkg::MODE_SYNC);
    localparam bit REWRITE   = REWRITE_EN;
    // resend has no effect unless rewrite is on
    localparam bit RESEND    = RESEND_EN && REWRITE_EN;

    // synchronised pin groups
    logic [WG-1:0] wgrp_s;
    logic [3:0]    rgrp_s;

    logic                  wclk_s;
    logic                  w_en;
    logic                  w_err;
    logic [DATA_WIDTH-1:0] w_data;
    logic                  rclk_s;
    logic                  r_en;
    logic                  r_nak;
    logic                  r_oe;

    // clock edge detection
    logic wclk_prev_q;
    logic wclk_prev_d;
    logic rclk_prev_q;
    logic rclk_prev_d;
    logic wr_tick;
    logic rd_tick;

    // write side state
    logic [PW-1:0] wptr_q;
    logic [PW-1:0] wptr_d;
    logic [PW-1:0] wstart_q;
    logic [PW-1:0] wstart_d;
    logic [PW-1:0] rview_q;
    logic [PW-1:0] rview_d;
    logic          full_q;
    logic          full_d;
    logic          afull_q;
    logic          afull_d;
    logic [PW-1:0] wfill;
    logic [PW-1:0] rlim_w;
    logic          mem_we;

    // read side state
    logic [PW-1:0]         rptr_q;
    logic [PW-1:0]         rptr_d;
    logic [PW-1:0]         rstart_q;
    logic [PW-1:0]         rstart_d;
    logic [PW-1:0]         wview_q;
    logic [PW-1:0]         wview_d;
    logic                  empty_q;
    logic                  empty_d;
    logic                  aempty_q;
    logic                  aempty_d;
    logic [DATA_WIDTH-1:0] rdata_q;
    logic [DATA_WIDTH-1:0] rdata_d;
    logic [DATA_WIDTH-1:0] dout_q;
    logic [DATA_WIDTH-1:0] dout_d;
    logic [PW-1:0]         rfill;
    logic [PW-1:0]         wlim_r;
    logic [PW-1:0]         rlim;
    logic [PW-1:0]         wlim;
    logic [DATA_WIDTH-1:0] mem_word;

    // clocks and their data share one delay, so they stay aligned
    pafifo_sync #(
        .WIDTH (WG)
    ) u_wsync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   ({write_clock, write_enable, write_packet_error, data_in}),
        .sync_out (wgrp_s)
    );

    pafifo_sync #(
        .WIDTH (4)
    ) u_rsync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .pin_in   ({read_clock, read_enable, read_resend_request,
                    output_register_enable}),
        .sync_out (rgrp_s)
    );

    // unpack synchronised groups; all enables active high
    always_comb begin
        wclk_s = wgrp_s[WG-1];
        w_en   = wgrp_s[WG-2];
        w_err  = wgrp_s[WG-3];
        w_data = wgrp_s[DATA_WIDTH-1:0];
        rclk_s = rgrp_s[3];
        r_en   = rgrp_s[2];
        r_nak  = rgrp_s[1];
        r_oe   = rgrp_s[0];
    end

    // rising edges of each pin clock become one-cycle ticks
    // sync mode: read side follows the shared write clock
    always_comb begin
        wclk_prev_d = wclk_s;
        rclk_prev_d = rclk_s;
        wr_tick     = wclk_s & ~wclk_prev_q;
        rd_tick     = SYNC_MODE ? wr_tick : (rclk_s & ~rclk_prev_q);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= wclk_prev_d;
            rclk_prev_q <= rclk_prev_d;
        end
    end

    // limits: the reader only sees whole packets, the writer must not
    // overwrite a packet that may still be resent
    always_comb begin
        wlim = REWRITE ? wstart_q : wptr_q;
        rlim = RESEND ? rstart_q : rptr_q;
    end

    pafifo_ram #(
        .DATA_WIDTH (DATA_WIDTH),
        .ADDR_WIDTH (ADDR_WIDTH)
    ) u_ram (
        .sys_clk   (sys_clk),
        .wr_strobe (mem_we),
        .wr_addr   (wptr_q[ADDR_WIDTH-1:0]),
        .wr_word   (w_data),
        .rd_addr   (rptr_q[ADDR_WIDTH-1:0]),
        .rd_word   (mem_word)
    );

    // write side next state
    always_comb begin
        wptr_d   = wptr_q;
        wstart_d = wstart_q;
        rview_d  = rview_q;
        full_d   = full_q;
        afull_d  = afull_q;
        mem_we   = 1'b0;
        // async: read limit passes one write-clock stage
        rlim_w   = SYNC_MODE ? rlim : rview_q;
        wfill    = wptr_q - rlim_w;
        if (wr_tick) begin
            rview_d = rlim;
            if (REWRITE && w_err) begin
                // drop the open packet, error wins over a write
                wptr_d = wstart_q;
            end else if (w_en && !full_q) begin
                // accept the word; no advance while full
                mem_we = 1'b1;
                wptr_d = wptr_q + PTR_ONE;
                // top data bit is the end-of-packet mark
                // next packet starts after the marked word
                if (REWRITE && w_data[DATA_WIDTH-1]) begin
                    wstart_d = wptr_q + PTR_ONE;
                end
            end
            // flags from the pointer as it will stand
            wfill   = wptr_d - rlim_w;
            full_d  = (wfill == DEPTH);
            afull_d = (wfill >= AFULL_LEVEL);
        end
    end

    // reset leaves both pointers and packet starts at zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wptr_q   <= '0;
            wstart_q <= '0;
            rview_q  <= '0;
            full_q   <= pafifo_pkg::RST_FULL;
            afull_q  <= pafifo_pkg::RST_ALMOST_FULL;
        end else begin
            wptr_q   <= wptr_d;
            wstart_q <= wstart_d;
            rview_q  <= rview_d;
            full_q   <= full_d;
            afull_q  <= afull_d;
        end
    end

    // read side next state
    always_comb begin
        rptr_d   = rptr_q;
        rstart_d = rstart_q;
        wview_d  = wview_q;
        empty_d  = empty_q;
        aempty_d = aempty_q;
        rdata_d  = rdata_q;
        dout_d   = dout_q;
        // async: write limit passes one read-clock stage
        wlim_r   = SYNC_MODE ? wlim : wview_q;
        rfill    = wlim_r - rptr_q;
        if (rd_tick) begin
            wview_d = wlim;
            if (RESEND && r_nak) begin
                // rewind to the start of the current packet
                rptr_d = rstart_q;
            end else if (r_en && !empty_q) begin
                // deliver the next word, ignored while empty
                rdata_d = mem_word;
                rptr_d  = rptr_q + PTR_ONE;
                // read-side packet start tracks marked words
                if (REWRITE && mem_word[DATA_WIDTH-1]) begin
                    rstart_d = rptr_q + PTR_ONE;
                end
            end
            // output register loads only when enabled
            if (r_oe) begin
                dout_d = rdata_q;
            end
            // registered flag: one tick late sync, two async
            rfill    = wlim_r - rptr_d;
            empty_d  = (rfill == '0);
            aempty_d = (rfill <= AEMPTY_LEVEL);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rptr_q   <= '0;
            rstart_q <= '0;
            wview_q  <= '0;
            empty_q  <= pafifo_pkg::RST_EMPTY;
            aempty_q <= pafifo_pkg::RST_ALMOST_EMPTY;
            rdata_q  <= '0;
            dout_q   <= '0;
        end else begin
            rptr_q   <= rptr_d;
            rstart_q <= rstart_d;
            wview_q  <= wview_d;
            empty_q  <= empty_d;
            aempty_q <= aempty_d;
            rdata_q  <= rdata_d;
            dout_q   <= dout_d;
        end
    end

    // all outputs straight from flops
    always_comb begin
        data_out          = dout_q;
        full_flag         = full_q;
        empty_flag        = empty_q;
        almost_full_flag  = afull_q;
        almost_empty_flag = aempty_q;
    end

endmodule

/* File: testbench/pafifo_top_asserts.sv */
`timescale 1ns/100ps
// port checker, single-clock mode with pin clock on write_clock
module pafifo_top_asserts #(
    parameter int unsigned DATA_WIDTH = pafifo_pkg::DATA_WIDTH_DEF
) (
    input wire logic                  sys_clk,
    input wire logic                  rst,
    input wire logic                  write_clock,
    input wire logic                  output_register_enable,
    input wire logic [DATA_WIDTH-1:0] data_out,
    input wire logic                  full_flag,
    input wire logic                  empty_flag,
    input wire logic                  almost_full_flag,
    input wire logic                  almost_empty_flag
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    a_full_not_empty: assert property (
        !(full_flag && empty_flag)) else $error("full and empty together");
    a_full_has_afull: assert property (
        full_flag |-> almost_full_flag) else $error("full without almost full");
    a_empty_has_aempty: assert property (
        empty_flag |-> almost_empty_flag) else $error("empty not almost empty");
    // output word only moves when its enable was held
    a_dout_needs_oe: assert property (
        $changed(data_out) |-> $past(output_register_enable, 3))
        else $error("data_out moved without enable");
    // everything moves 3 to 4 cycles after a pin clock rise
    a_dout_on_tick: assert property (
        $changed(data_out) |-> $past(write_clock, 2) && !$past(write_clock, 6))
        else $error("data_out moved off a tick");
    a_full_on_tick: assert property (
        $changed(full_flag) |-> $past(write_clock, 2) && !$past(write_clock, 6))
        else $error("full_flag moved off a tick");
    a_empty_clear_tick: assert property (
        $fell(empty_flag) |-> $past(write_clock, 2) && !$past(write_clock, 6))
        else $error("empty_flag cleared off a tick");
    a_afull_on_tick: assert property (
        $changed(almost_full_flag) |-> $past(write_clock, 2))
        else $error("almost_full_flag moved off a tick");
endmodule

bind pafifo_top pafifo_top_asserts #(.DATA_WIDTH(DATA_WIDTH)) i_chk (
    .sys_clk                (sys_clk),
    .rst                    (rst),
    .write_clock            (write_clock),
    .output_register_enable (output_register_enable),
    .data_out               (data_out),
    .full_flag              (full_flag),
    .empty_flag             (empty_flag),
    .almost_full_flag       (almost_full_flag),
    .almost_empty_flag      (almost_empty_flag)
);

/* File: testbench/pafifo_user_model.sv */
`timescale 1ns/100ps
// pin-side user logic: one pin clock pulse per request, idle otherwise
module pafifo_user_model (
    input  wire logic       sys_clk,
    input  wire logic       go,
    input  wire logic       we,
    input  wire logic       re,
    input  wire logic       oe,
    input  wire logic [3:0] word,
    output logic            pin_clk,
    output logic            write_enable,
    output logic [3:0]      data_in,
    output logic            read_enable,
    output logic            output_register_enable,
    output logic            done
);
    logic [4:0] cnt;

    initial begin
        cnt = 5'h00;
        pin_clk = 1'b0;
        write_enable = 1'b0;
        data_in = 4'h0;
        read_enable = 1'b0;
        output_register_enable = 1'b0;
        done = 1'b0;
    end

    // pins set 8 cycles before the rise and held past the fall;
    // 10 cycles high and 11 low between back-to-back requests (168 ns)
    // enables high only to ask
    always @(posedge sys_clk) begin
        done <= 1'b0;
        if (go && cnt == 5'h00) begin
            write_enable <= we;
            read_enable <= re;
            output_register_enable <= oe;
            // top bit would carry the end-of-packet mark
            data_in <= we ? word : ~data_in; // inverted when not writing: no stale value
            cnt <= 5'h01;
        end else if (cnt != 5'h00) begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h08) pin_clk <= 1'b1;
            if (cnt == 5'h12) begin
                pin_clk <= 1'b0;
                done <= 1'b1;
                cnt <= 5'h00;
            end
        end
    end
endmodule

/* File: testbench/pafifo_top_tb.sv */
`timescale 1ns/100ps
module pafifo_top_tb;
    localparam int DEPTH = 16;
    localparam int AFULL_LVL = DEPTH - int'(pafifo_pkg::AFULL_OFFSET_DEF);
    localparam int AEMPTY_LVL = int'(pafifo_pkg::AEMPTY_OFFSET_DEF);
    logic       sys_clk = 1'b0;
    logic       rst = 1'b1;
    logic       go = 1'b0;
    logic       we = 1'b0;
    logic       re = 1'b0;
    logic       oe = 1'b0;
    logic [3:0] word = 4'h0;
    logic       pin_clk, w_en, r_en, o_en, done;
    logic       full_e, empty_e;
    logic [3:0] d_in, data_out, latch_e, dout_e;
    logic       full_flag, empty_flag, almost_full_flag, almost_empty_flag;
    logic [3:0] q[$];
    logic [7:0] lf;
    int         fill, prev, err_total, total_checks;

    always #4 sys_clk = ~sys_clk;

    pafifo_user_model i_user (.sys_clk(sys_clk), .go(go), .we(we), .re(re),
        .oe(oe), .word(word), .pin_clk(pin_clk), .write_enable(w_en),
        .data_in(d_in), .read_enable(r_en), .output_register_enable(o_en),
        .done(done));

    pafifo_top #(.SYNC_FIFO(pafifo_pkg::MODE_SYNC), .REWRITE_EN(1'b0),
        .RESEND_EN(1'b0)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .write_clock(pin_clk),
        .write_enable(w_en), .data_in(d_in), .write_packet_error(1'b0),
        .read_clock(pin_clk), .read_enable(r_en), .read_resend_request(1'b0),
        .output_register_enable(o_en), .data_out(data_out),
        .full_flag(full_flag), .empty_flag(empty_flag),
        .almost_full_flag(almost_full_flag),
        .almost_empty_flag(almost_empty_flag));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %0b seen %0b", nm, e, g);
        end
    endtask

    task automatic cmp_word(input string nm, input logic [3:0] e,
                            input logic [3:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // write-side flags see this tick's write but the read only a tick
    // later; read-side flags the other way round; refusals follow flags
    task automatic tick(input logic w, input logic r, input logic o,
                        input logic [3:0] d);
        int  n;
        logic wok, rok;
        wok = w && !full_e;
        rok = r && !empty_e;
        @(posedge sys_clk);
        go <= 1'b1;
        we <= w;
        re <= r;
        oe <= o;
        word <= d;
        @(posedge sys_clk);
        go <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 100) begin
            err_total++;
            end_of_test();
        end
        prev = fill;
        if (o) dout_e = latch_e;
        if (rok) begin
            latch_e = q.pop_front();
            fill--;
        end
        if (wok) begin
            q.push_back(d);
            fill++;
        end
        full_e = (prev + int'(wok)) == DEPTH;
        empty_e = (prev - int'(rok)) == 0;
        cmp_word("data_out", dout_e, data_out);
        cmp_bit("full_flag", full_e, full_flag);
        cmp_bit("empty_flag", empty_e, empty_flag);
        cmp_bit("almost_full", (prev + int'(wok)) >= AFULL_LVL,
                almost_full_flag);
        cmp_bit("almost_empty", (prev - int'(rok)) <= AEMPTY_LVL,
                almost_empty_flag);
    endtask

    task automatic do_reset(input int cycles);
        rst <= 1'b1;
        repeat (cycles) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        q.delete();
        fill = 0;
        prev = 0;
        latch_e = 4'h0;
        dout_e = 4'h0;
        full_e = 1'b0;
        empty_e = 1'b1;
        cmp_word("data_out", 4'h0, data_out);
        cmp_bit("full_flag", 1'b0, full_flag);
        cmp_bit("empty_flag", 1'b1, empty_flag);
        cmp_bit("almost_full", 1'b0, almost_full_flag);
        cmp_bit("almost_empty", 1'b1, almost_empty_flag);
    endtask

    initial begin
        lf = 8'h34;
        err_total = 0;
        total_checks = 0;
        do_reset(16);
        // fill one past full: last write must be dropped
        for (int i = 0; i <= DEPTH; i++) tick(1'b1, 1'b0, 1'b0, 4'(i));
        // drain past empty with the output register loading
        for (int i = 0; i < DEPTH + 3; i++) tick(1'b0, 1'b1, 1'b1, 4'hF);
        // random mix of writes, reads and register loads
        for (int i = 0; i < 400; i++) begin
            lf = lfsr(lf);
            tick(lf[0], lf[1], lf[2], lf[7:4]);
        end
        // reset mid-run with data stored, then a read must be refused
        for (int i = 0; i < 5; i++) tick(1'b1, 1'b0, 1'b0, 4'hA);
        do_reset(2);
        tick(1'b0, 1'b1, 1'b1, 4'h0);
        tick(1'b0, 1'b1, 1'b1, 4'h0);
        end_of_test();
    end
endmodule
